// ==== hdl/cre_pkg.sv ====
// cre_pkg.sv: register map, field layout and constants of the crc engine
// assumes a plain register port with byte addresses and 32-bit data
package cre_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CRE_OFF_CTRL = 8'h00;
  localparam logic [7:0] CRE_OFF_POLY = 8'h04;
  localparam logic [7:0] CRE_OFF_DATA = 8'h08;
  localparam logic [7:0] CRE_OFF_RESULT = 8'h0C;

  // ----------------------------------------------------------------
  // control register field positions
  // ----------------------------------------------------------------
  localparam int CRE_CTRL_MODE16 = 0;
  localparam int CRE_CTRL_WIDTH_LO = 1;
  localparam int CRE_CTRL_BITREV = 3;
  localparam int CRE_CTRL_BYTESWAP = 4;
  localparam int CRE_CTRL_OUTREV = 5;
  localparam int CRE_CTRL_OUTHALF = 6;
  localparam int CRE_CTRL_SNOOP_EN = 7;
  localparam int CRE_CTRL_SNOOP_RD = 8;
  localparam int CRE_CTRL_SEL_LO = 9;
  localparam int CRE_CTRL_SEED_LOAD = 13;
  localparam int CRE_CTRL_SEED_ONES = 14;

  // ----------------------------------------------------------------
  // polynomials, seeds and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CRE_POLY32 = 32'h04C11DB7;
  localparam logic [15:0] CRE_POLY16_RST = 16'h1021;
  localparam logic [31:0] CRE_CRC_RST = 32'h00000000;
  localparam logic [31:0] CRE_SEED32 = 32'hFFFFFFFF;
  localparam logic [31:0] CRE_SEED16 = 32'h0000FFFF;
  localparam logic [1:0] CRE_WIDTH_RST = 2'h0;

  // ----------------------------------------------------------------
  // input block widths: field codes and bit counts
  // ----------------------------------------------------------------
  localparam logic [1:0] CRE_W32 = 2'h0;
  localparam logic [1:0] CRE_W16 = 2'h1;
  localparam logic [5:0] CRE_NB32 = 6'h20;
  localparam logic [5:0] CRE_NB16 = 6'h10;
  localparam logic [5:0] CRE_NB8 = 6'h08;

  // ----------------------------------------------------------------
  // complete state of the engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] crc;
    logic mode16;
    logic [1:0] width;
    logic in_bitrev;
    logic in_byteswap;
    logic out_rev;
    logic out_half;
    logic snoop_en;
    logic snoop_rd;
    logic [3:0] snoop_sel;
    logic [15:0] poly16;
    logic [31:0] rdata;
  } cre_state_t;

endpackage

// ==== hdl/cre_fold.sv ====
// cre_fold.sv: single-cycle unrolled crc fold of up to 32 input bits
// assumes data left aligned (first bit in bit 31), msb-first shifting
`timescale 1ns/1ps
`default_nettype none
module cre_fold
  import cre_pkg::*;
(
  input wire logic [31:0] crc_in,
  input wire logic [31:0] data_in,
  input wire logic [5:0] nbits,
  input wire logic mode16,
  input wire logic [15:0] poly16,
  output logic [31:0] crc_out
);

  logic [31:0] stage [0:32];

  assign stage[0] = crc_in;

  // one shift step per input bit, skipped beyond nbits
  for (genvar gi = 0; gi < 32; gi++)
  begin : g_bit
    localparam logic [5:0] IDX = 6'(gi);
    logic fb32;
    logic fb16;
    logic [31:0] n32;
    logic [31:0] n16;
    assign fb32 = stage[gi][31] ^ data_in[31 - gi];
    assign fb16 = stage[gi][15] ^ data_in[31 - gi];
    assign n32 = {stage[gi][30:0], 1'b0} ^ (fb32 ? CRE_POLY32 : 32'h00000000);
    assign n16 = {16'h0000, stage[gi][14:0], 1'b0} ^ {16'h0000, fb16 ? poly16 : 16'h0000};
    assign stage[gi + 1] = (IDX < nbits) ? (mode16 ? n16 : n32) : stage[gi];
  end

  assign crc_out = stage[32];

endmodule
`default_nettype wire

// ==== hdl/cre_top.sv ====
// cre_top.sv: crc engine with register port and peripheral bus snoop
// assumes one clock; snooped bus and register port run on clk
`timescale 1ns/1ps
`default_nettype none

module cre_top
  import cre_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic [31:0] crc_value,
  input wire logic [15:0] snp_psel,
  input wire logic snp_penable,
  input wire logic snp_pwrite,
  input wire logic snp_pready,
  input wire logic [31:0] snp_pwdata,
  input wire logic [31:0] snp_prdata
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;

  // two-stage release of the async reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_sync <= 2'b00;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  cre_state_t st;
  cre_state_t next_st;
  logic wr_ctrl;
  logic wr_poly;
  logic wr_data;
  logic seed_wr;
  logic snoop_hit;
  logic feed;
  logic [31:0] raw;
  logic [31:0] rev_bytes;
  logic [31:0] in_bits;
  logic [31:0] swapped;
  logic [31:0] aligned;
  logic [5:0] nbits;
  logic [31:0] fold_out;
  logic [31:0] res_view;
  logic [31:0] rev_word;
  logic [31:0] ctrl_view;
  logic [31:0] seed_val;
  logic new_mode16;

  assign wr_ctrl = wr_en && (addr == CRE_OFF_CTRL);
  assign wr_poly = wr_en && (addr == CRE_OFF_POLY);
  assign wr_data = wr_en && (addr == CRE_OFF_DATA);
  assign seed_wr = wr_ctrl && wdata[CRE_CTRL_SEED_LOAD];

  assign snoop_hit = st.snoop_en && snp_psel[st.snoop_sel] && snp_penable
                     && snp_pready && (snp_pwrite != st.snoop_rd);

  // direct write wins; a seed write drops a coincident snoop beat
  assign feed = wr_data || (snoop_hit && !seed_wr);
  assign raw = wr_data ? wdata : (st.snoop_rd ? snp_prdata : snp_pwdata);

  // ----------------------------------------------------------------
  // input reordering
  // ----------------------------------------------------------------
  // mirror bits in each byte
  for (genvar gb = 0; gb < 4; gb++)
  begin : g_byte
    assign rev_bytes[8 * gb +: 8] = {<<{raw[8 * gb +: 8]}};
  end

  assign in_bits = st.in_bitrev ? rev_bytes : raw;

  // byte order swap per block width
  always_comb
  begin
    swapped = in_bits;
    if (st.in_byteswap)
    begin
      case (st.width)
        CRE_W32: swapped = {in_bits[7:0], in_bits[15:8], in_bits[23:16], in_bits[31:24]};
        CRE_W16: swapped = {in_bits[31:16], in_bits[7:0], in_bits[15:8]};
        default: swapped = in_bits;
      endcase
    end
  end

  // left align the block and pick its bit count
  always_comb
  begin
    case (st.width)
      CRE_W32:
      begin
        aligned = swapped;
        nbits = CRE_NB32;
      end
      CRE_W16:
      begin
        aligned = {swapped[15:0], 16'h0000};
        nbits = CRE_NB16;
      end
      default:
      begin
        aligned = {swapped[7:0], 24'h000000};
        nbits = CRE_NB8;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // unrolled fold
  // ----------------------------------------------------------------
  // one block per clock
  cre_fold u_fold (
    .crc_in(st.crc),
    .data_in(aligned),
    .nbits(nbits),
    .mode16(st.mode16),
    .poly16(st.poly16),
    .crc_out(fold_out)
  );

  // ----------------------------------------------------------------
  // read views
  // ----------------------------------------------------------------
  // whole-word mirror of the crc, halves swapped back below in 16-bit mode or with out_half set
  assign rev_word = {<<{st.crc}};

  always_comb
  begin
    res_view = st.crc;
    if (st.out_rev)
    begin
      if (st.mode16 || st.out_half)
      begin
        res_view = {rev_word[15:0], rev_word[31:16]};
      end
      else
      begin
        res_view = rev_word;
      end
      if (st.mode16)
      begin
        res_view[31:16] = 16'h0000;
      end
    end
  end

  // control readback, strobe bits read zero
  always_comb
  begin
    ctrl_view = 32'h00000000;
    ctrl_view[CRE_CTRL_MODE16] = st.mode16;
    ctrl_view[CRE_CTRL_WIDTH_LO +: 2] = st.width;
    ctrl_view[CRE_CTRL_BITREV] = st.in_bitrev;
    ctrl_view[CRE_CTRL_BYTESWAP] = st.in_byteswap;
    ctrl_view[CRE_CTRL_OUTREV] = st.out_rev;
    ctrl_view[CRE_CTRL_OUTHALF] = st.out_half;
    ctrl_view[CRE_CTRL_SNOOP_EN] = st.snoop_en;
    ctrl_view[CRE_CTRL_SNOOP_RD] = st.snoop_rd;
    ctrl_view[CRE_CTRL_SEL_LO +: 4] = st.snoop_sel;
  end

  // seed follows the newly written mode
  assign new_mode16 = wdata[CRE_CTRL_MODE16];
  assign seed_val = !wdata[CRE_CTRL_SEED_ONES] ? CRE_CRC_RST
                    : (new_mode16 ? CRE_SEED16 : CRE_SEED32);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.rdata = 32'h00000000;
    if (feed)
    begin
      next_st.crc = fold_out;
    end
    if (wr_ctrl)
    begin
      next_st.mode16 = wdata[CRE_CTRL_MODE16];
      next_st.width = wdata[CRE_CTRL_WIDTH_LO +: 2];
      next_st.in_bitrev = wdata[CRE_CTRL_BITREV];
      next_st.in_byteswap = wdata[CRE_CTRL_BYTESWAP];
      next_st.out_rev = wdata[CRE_CTRL_OUTREV];
      next_st.out_half = wdata[CRE_CTRL_OUTHALF];
      next_st.snoop_en = wdata[CRE_CTRL_SNOOP_EN];
      next_st.snoop_rd = wdata[CRE_CTRL_SNOOP_RD];
      next_st.snoop_sel = wdata[CRE_CTRL_SEL_LO +: 4];
      if (seed_wr)
      begin
        next_st.crc = seed_val;
      end
    end
    if (wr_poly)
    begin
      next_st.poly16 = wdata[15:0];
    end
    if (rd_en)
    begin
      case (addr)
        CRE_OFF_CTRL: next_st.rdata = ctrl_view;
        CRE_OFF_POLY: next_st.rdata = {16'h0000, st.poly16};
        CRE_OFF_DATA: next_st.rdata = st.crc;
        CRE_OFF_RESULT: next_st.rdata = res_view;
        default: next_st.rdata = 32'h00000000;
      endcase
    end
    // upper half cleared in 16-bit mode
    if (next_st.mode16)
    begin
      next_st.crc[31:16] = 16'h0000;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '{crc: CRE_CRC_RST, mode16: 1'b0, width: CRE_WIDTH_RST,
              in_bitrev: 1'b0, in_byteswap: 1'b0, out_rev: 1'b0,
              out_half: 1'b0, snoop_en: 1'b0, snoop_rd: 1'b0,
              snoop_sel: 4'h0, poly16: CRE_POLY16_RST, rdata: 32'h00000000};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign crc_value = st.crc;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // plain mirrors used as independent references by the checks
  logic [31:0] raw_mirror;
  logic [31:0] rdata_mirror;
  assign raw_mirror = {<<{raw}};
  assign rdata_mirror = {<<{rdata}};

  sequence s_seed_wr;
    wr_en && (addr == CRE_OFF_CTRL) && wdata[CRE_CTRL_SEED_LOAD];
  endsequence

  sequence s_two_words;
    wr_data && (st.width == CRE_W32) ##1 wr_data && (st.width == CRE_W32) && !wr_ctrl;
  endsequence

  sequence s_one_bit;
    feed && !seed_wr && !wr_poly && (nbits == CRE_NB8) && (st.crc == 32'h00000000)
    && (aligned == 32'h01000000);
  endsequence

  AST_POLY32_BIT: assert property (
    (s_one_bit and (!st.mode16)) |=> (st.crc == 32'h04C11DB7))
    else $error("single bit did not yield the fixed generator");

  AST_POLY16_BIT: assert property (
    (s_one_bit and st.mode16) |=> (st.crc == {16'h0000, $past(st.poly16)}))
    else $error("single bit did not yield the programmed generator");

  AST_DIRECT_FOLD: assert property (
    wr_data |=> (st.crc == ($past(st.mode16) ? {16'h0000, $past(fold_out[15:0])}
                                              : $past(fold_out))))
    else $error("data write did not update the crc");

  AST_HOLD: assert property (
    !feed && !seed_wr |=> (st.crc[15:0] == $past(st.crc[15:0]))
    && (st.mode16 || (st.crc[31:16] == $past(st.crc[31:16]))))
    else $error("crc changed without input");

  AST_SNOOP_FEED: assert property (
    snoop_hit && !wr_data && !seed_wr |-> feed
    && (raw == (st.snoop_rd ? snp_prdata : snp_pwdata)))
    else $error("snooped transfer not fed");

  AST_BITREV: assert property (
    st.in_bitrev && !st.in_byteswap |->
    (in_bits == {raw_mirror[7:0], raw_mirror[15:8], raw_mirror[23:16], raw_mirror[31:24]}))
    else $error("input bits not mirrored per byte");

  AST_BYTESWAP: assert property (
    st.in_byteswap && (st.width == CRE_W32) |->
    (swapped == {in_bits[7:0], in_bits[15:8], in_bits[23:16], in_bits[31:24]}))
    else $error("byte order not reversed");

  AST_OUT_HALF: assert property (
    rd_en && (addr == CRE_OFF_RESULT) && st.out_rev && st.out_half && !st.mode16
    |=> (rdata_mirror == {$past(st.crc[15:0]), $past(st.crc[31:16])}))
    else $error("half-word result reversal wrong");

  AST_SEED: assert property (
    s_seed_wr |=> (st.crc == $past(seed_val))
    && (st.mode16 == $past(wdata[CRE_CTRL_MODE16])))
    else $error("config write did not seed the crc");

  AST_B2B: assert property (
    s_two_words |=> (st.crc == $past(fold_out)) && ($past(st.crc) == $past(fold_out, 2)))
    else $error("back to back words not both folded");

  AST_UPPER16: assert property (
    st.mode16 |-> (st.crc[31:16] == 16'h0000) ##1 (!st.mode16 || crc_value[31:16] == 16'h0000))
    else $error("upper half not zero in 16-bit mode");

endmodule
`default_nettype wire

// ==== bench/cre_pbus_model.sv ====
// cre_pbus_model.sv: peripheral bus master whose beats the snoop port watches
// assumes one transfer at a time, started from the clk domain via xfer
`timescale 1ns/1ps
`default_nettype none
module cre_pbus_model
  import cre_pkg::*;
(
  input wire logic clk,
  output logic [15:0] psel,
  output logic penable,
  output logic pwrite,
  output logic pready,
  output logic [31:0] pwdata,
  output logic [31:0] prdata
);
  // quiet bus at time zero
  initial
  begin
    psel = 16'h0000;
    penable = 1'b0;
    pwrite = 1'b0;
    pready = 1'b0;
    pwdata = 32'h00000000;
    prdata = 32'h00000000;
  end

  task automatic xfer(input logic w, input logic [3:0] idx, input logic [31:0] d, input bit slow);
    @(posedge clk);
    psel <= 16'h0001 << idx;
    pwrite <= w;
    if (w)
      pwdata <= d;
    else
      prdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    pready <= !slow;
    // one wait state when slow
    if (slow)
    begin
      @(posedge clk);
      pready <= 1'b1;
    end
    // released data no longer shows the beat
    @(posedge clk);
    psel <= 16'h0000;
    penable <= 1'b0;
    pready <= 1'b0;
    pwdata <= ~pwdata;
    prdata <= ~prdata;
  endtask
endmodule
`default_nettype wire

// ==== bench/test_crc_engine_with_bus_snoop.sv ====
// test_crc_engine_with_bus_snoop.sv: self-checking bench for cre_top
// assumes cre_pkg, cre_top and cre_pbus_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_crc_engine_with_bus_snoop
  import cre_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata, crc_value, pwdata, prdata, v, w, k;
  logic [15:0] psel, p;
  logic penable, pwrite, pready;
  logic [63:0] e;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  // control words: mode, width, reorder and output options
  logic [31:0] tc [12] = '{32'h6000, 32'h6003, 32'h2004, 32'h6005, 32'h6006, 32'h6008,
    32'h6010, 32'h6013, 32'h6020, 32'h6060, 32'h6039, 32'h2014};

  // clock 10 MHz
  always #50 clk = ~clk;

  cre_top dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .crc_value(crc_value), .snp_psel(psel),
    .snp_penable(penable), .snp_pwrite(pwrite), .snp_pready(pready),
    .snp_pwdata(pwdata), .snp_prdata(prdata));

  cre_pbus_model pm (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pwdata(pwdata), .prdata(prdata));

  // bit serial reference, msb first
  function automatic logic [31:0] fold(logic [31:0] c, logic [31:0] d, int n, logic m,
    logic [15:0] q);
    for (int i = n - 1; i >= 0; i--)
      if (m)
        c = {16'h0000, c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? {16'h0000, q} : 32'h00000000);
      else
        c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRE_POLY32 : 32'h00000000);
    return c;
  endfunction

  // expected {result, crc} after seed write and one data write
  function automatic logic [63:0] ref_row(logic [31:0] c, logic [15:0] q, logic [31:0] x);
    logic m;
    int n;
    logic [31:0] d, r, s;
    m = c[0];
    n = (c[2:1] == 2'h0) ? 32 : (c[2:1] == 2'h1) ? 16 : 8;
    r = c[14] ? (m ? CRE_SEED16 : CRE_SEED32) : CRE_CRC_RST;
    d = x;
    if (c[3])
      for (int i = 0; i < 32; i++)
        d[i] = x[(i & ~7) | (7 - (i & 7))];
    s = d;
    if (c[4] && n == 32)
      d = {s[7:0], s[15:8], s[23:16], s[31:24]};
    if (c[4] && n == 16)
      d = {s[31:16], s[7:0], s[15:8]};
    r = fold(r, d, n, m, q);
    s = r;
    if (c[5])
      for (int i = 0; i < 32; i++)
        s[i] = m ? (i < 16 ? r[15 - i] : 1'b0) : c[6] ? r[(i & 16) | (15 - (i & 15))] : r[31 - i];
    return {s, r};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    rd_en <= 1'b0;
  endtask

  task automatic idle();
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      close_out();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    w = 32'h1A2B3C4D;
    // table of modes, one seed and one data word each
    for (int i = 0; i < 12; i++)
    begin
      p = i[0] ? 16'h8005 : 16'h3D65;
      e = ref_row(tc[i], p, w);
      wr(CRE_OFF_POLY, {16'h0000, p});
      wr(CRE_OFF_CTRL, tc[i]);
      wr(CRE_OFF_DATA, w);
      idle();
      #1 chk("crc", crc_value, e[31:0]);
      rd(CRE_OFF_RESULT, v);
      chk("result", v, e[63:32]);
      rd(CRE_OFF_DATA, v);
      chk("raw", v, e[31:0]);
      $display("row %0d done", i);
      w = w + 32'h01020304;
    end
    // one word folded every clock
    wr(CRE_OFF_CTRL, 32'h6000);
    k = CRE_SEED32;
    for (int i = 1; i < 5; i++)
    begin
      wr(CRE_OFF_DATA, 32'h11111111 * i);
      k = fold(k, 32'h11111111 * i, 32, 1'b0, 16'h0000);
    end
    idle();
    #1 chk("burst", crc_value, k);
    wr(CRE_OFF_CTRL, 32'h0001);
    idle();
    #1 chk("no seed", crc_value, {16'h0000, k[15:0]});
    wr(8'h10, 32'hFFFFFFFF);
    idle();
    #1 chk("unmapped wr", crc_value, {16'h0000, k[15:0]});
    rd(8'h10, v);
    chk("unmapped rd", v, 32'h00000000);
    $display("burst test done");
    // single set bit last in an 8-bit block yields the generator
    wr(CRE_OFF_POLY, 32'h0000589B);
    wr(CRE_OFF_CTRL, 32'h2004);
    wr(CRE_OFF_DATA, 32'h00000001);
    idle();
    #1 chk("one bit 32", crc_value, CRE_POLY32);
    wr(CRE_OFF_CTRL, 32'h2005);
    wr(CRE_OFF_DATA, 32'h00000001);
    idle();
    #1 chk("one bit 16", crc_value, 32'h0000589B);
    $display("generator test done");
    // snoop writes, then reads, of peripheral 3 only
    wr(CRE_OFF_CTRL, 32'h2680);
    idle();
    pm.xfer(1'b1, 4'h3, 32'hCAFE0001, 1'b1);
    k = fold(32'h00000000, 32'hCAFE0001, 32, 1'b0, 16'h0000);
    #1 chk("snoop wr", crc_value, k);
    pm.xfer(1'b1, 4'h2, 32'h12345678, 1'b0);
    pm.xfer(1'b0, 4'h3, 32'h0BADF00D, 1'b0);
    #1 chk("snoop skip", crc_value, k);
    wr(CRE_OFF_CTRL, 32'h2780);
    idle();
    pm.xfer(1'b0, 4'h3, 32'h89ABCDEF, 1'b0);
    #1 chk("snoop rd", crc_value, fold(32'h00000000, 32'h89ABCDEF, 32, 1'b0, 16'h0000));
    $display("snoop test done");
    // reset in mid-run
    @(posedge clk);
    arst_n <= 1'b0;
    #1 chk("reset crc", crc_value, CRE_CRC_RST);
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(CRE_OFF_CTRL, v);
    chk("reset ctrl", v, 32'h00000000);
    rd(CRE_OFF_POLY, v);
    chk("reset poly", v, {16'h0000, CRE_POLY16_RST});
    $display("reset test done");
    close_out();
  end
endmodule
`default_nettype wire
